/* rtl/cpi_pkg.sv */
package cpi_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REC_W = 24;
  localparam int NUM_REC = 4;
  localparam int PTR_W = 2;
  localparam int NUM_PIN = 2;
  localparam int PIN_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_PIN_DATA = 8'h08;
  localparam logic [7:0] OFF_INC_VAL = 8'h0c;
  localparam logic [7:0] OFF_FILE_CFG = 8'h10;
  localparam logic [7:0] OFF_REF_PIN0 = 8'h14;
  localparam logic [7:0] OFF_REF_PIN1 = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_RESP_NEW = 8'h20;
  localparam logic [7:0] OFF_RESP_ADD = 8'h24;
  localparam logic [7:0] OFF_PIN_STATE = 8'h28;
  localparam logic [7:0] OFF_REC_CUR = 8'h2c;
  localparam logic [7:0] OFF_REC_LOAD = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_EMPTY_BIT = 2;
  localparam int CMD_KEY_BIT = 3;
  localparam int FCFG_INC_BIT = 0;
  localparam int FCFG_PROT_BIT = 1;
  localparam int FCFG_KEY_BIT = 2;
  localparam int CTRL_SESSION_BIT = 0;
  localparam int CTRL_UNBLOCK_BIT = 1;
  localparam int CTRL_DISABLE_BIT = 2;
  localparam int CTRL_ENABLE_BIT = 3;
  localparam int CTRL_KEY_BIT = 4;
  localparam int STAT_BUSY_BIT = 16;
  localparam int PSTATE_STRIDE = 8;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_VERIFY = 2'h0;
  localparam logic [1:0] OP_INCREASE = 2'h1;
  localparam logic [1:0] OP_ACCESS = 2'h2;

  // ----------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_SEC = 16'h6982;
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_NOT_USABLE = 16'h6984;
  localparam logic [15:0] SW_NOT_ALLOWED = 16'h6986;
  localparam logic [15:0] SW_MAX = 16'h9850;
  localparam logic [15:0] SW_BAD_OP = 16'h6d00;
  localparam logic [15:0] SW_RETRY_BASE = 16'h63c0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RETRY_INIT = 2'h3;
  localparam logic [23:0] REC_RST = 24'h000000;
  localparam logic [31:0] PIN_RST = 32'h00000000;
  localparam logic [15:0] SW_RST = 16'h0000;

  // Command engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cpi_state_e;

endpackage

/* rtl/cpi_top.sv */
`timescale 1ns/10ps
// How it works
// - Increase adds value to newest, writes oldest
// - Written record becomes current record one
// - Increase without access answers 6982
// - Success returns new value and added value
// - Sum overflow leaves file, answers 9850
// - Increase not in access rule refused
// - Matching PIN answers 9000
// - Verify accepts PIN value or empty data
// - Verified state shared by all channels
// - Data verify refused while PIN disabled
// - Protected function refused until verified or PIN disabled
// - Correct PIN restores retry count three
// - Wrong PIN decrements retries on any channel
// - Wrong PIN answers 63C2 then 63C1
// - Third wrong PIN blocks, answers 63C0
// - Data verify on blocked PIN answers 6983
// - Blocked PIN keeps access unmet until unblock
// - Empty verify only reports selected retries
// - Empty verify runs in every PIN state
// - Retries reported in low digit 63CX
// - Empty verify on blocked PIN answers 63C0
module cpi_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [cpi_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cpi_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [cpi_pkg::DATA_W-1:0] o_rdata,
  // Command answer
  output logic [15:0] o_sw,
  output logic o_done,
  output logic o_busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cpi_pkg::cpi_state_e state_q;
  logic [1:0] cmd_op_q;
  logic cmd_empty_q, cmd_key_q;
  logic [cpi_pkg::PIN_W-1:0] pin_data_q;
  logic [cpi_pkg::REC_W-1:0] inc_val_q;
  logic [2:0] fcfg_q;
  logic [cpi_pkg::PIN_W-1:0] ref_pin_q [cpi_pkg::NUM_PIN];
  logic [1:0] retry_q [cpi_pkg::NUM_PIN];
  logic [cpi_pkg::NUM_PIN-1:0] blocked_q, disabled_q, verified_q;
  logic [cpi_pkg::REC_W-1:0] rec_q [cpi_pkg::NUM_REC];
  logic [cpi_pkg::PTR_W-1:0] ptr_q;
  logic [cpi_pkg::REC_W-1:0] resp_new_q, resp_add_q;
  logic [15:0] sw_q;
  logic done_q;
  logic [cpi_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic is_exec, cmd_wr, ctrl_wr;
  logic [cpi_pkg::PTR_W-1:0] oldest;
  logic [cpi_pkg::REC_W:0] inc_sum;
  logic [cpi_pkg::REC_W-1:0] inc_sum_lo;
  logic inc_carry, inc_acc, file_acc, pin_match;
  logic [1:0] cur_retry;
  logic cur_blocked, cur_disabled, v_good, v_bad, inc_ok;
  logic [15:0] sw_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match for one register
  function automatic logic hit(input logic [cpi_pkg::ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  // Access condition: unprotected, PIN disabled, or PIN verified
  function automatic logic acc_met(input logic prot, input logic dis, input logic ver);
    acc_met = !prot || dis || ver;
  endfunction

  assign is_exec = (state_q == cpi_pkg::ST_EXEC);
  assign cmd_wr = i_wr && hit(i_addr, cpi_pkg::OFF_CMD);
  assign ctrl_wr = i_wr && hit(i_addr, cpi_pkg::OFF_CTRL);
  assign o_rdata = rdata_q;
  assign o_sw = sw_q;
  assign o_done = done_q;
  assign o_busy = state_q[1];

  // Operand views for the latched command
  assign cur_retry = retry_q[cmd_key_q];
  assign cur_blocked = blocked_q[cmd_key_q];
  assign cur_disabled = disabled_q[cmd_key_q];
  assign pin_match = (pin_data_q == ref_pin_q[cmd_key_q]);
  assign oldest = ptr_q + 2'h1;
  assign inc_sum = {1'b0, rec_q[ptr_q]} + {1'b0, inc_val_q};
  assign inc_sum_lo = inc_sum[cpi_pkg::REC_W-1:0];
  assign inc_carry = inc_sum[cpi_pkg::REC_W];
  // Global security state, no channel term
  assign file_acc = acc_met(fcfg_q[cpi_pkg::FCFG_PROT_BIT],
                            disabled_q[fcfg_q[cpi_pkg::FCFG_KEY_BIT]],
                            verified_q[fcfg_q[cpi_pkg::FCFG_KEY_BIT]]);
  assign inc_acc = fcfg_q[cpi_pkg::FCFG_INC_BIT] && file_acc;
  assign inc_ok = is_exec && (cmd_op_q == cpi_pkg::OP_INCREASE) && inc_acc && !inc_carry;

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  // Idle to exec on command write; writes while busy are dropped
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= cpi_pkg::ST_IDLE;
    end else begin
      case (state_q)
        cpi_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            state_q <= cpi_pkg::ST_EXEC;
          end
        end
        cpi_pkg::ST_EXEC: state_q <= cpi_pkg::ST_IDLE;
        default: state_q <= cpi_pkg::ST_IDLE;
      endcase
    end
  end

  // Command fields latch
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_op_q <= cpi_pkg::OP_VERIFY;
      cmd_empty_q <= 1'b0;
      cmd_key_q <= 1'b0;
    end else if (cmd_wr && !is_exec) begin
      cmd_op_q <= i_wdata[cpi_pkg::CMD_OP_LSB +: 2];
      cmd_empty_q <= i_wdata[cpi_pkg::CMD_EMPTY_BIT];
      cmd_key_q <= i_wdata[cpi_pkg::CMD_KEY_BIT];
    end
  end

  // Status word decision for the executing command
  always_comb begin
    sw_d = cpi_pkg::SW_BAD_OP;
    v_good = 1'b0;
    v_bad = 1'b0;
    case (cmd_op_q)
      cpi_pkg::OP_VERIFY: begin
        if (cmd_empty_q) begin
          if (cur_blocked) begin
            sw_d = cpi_pkg::SW_RETRY_BASE;
          end else begin
            sw_d = {cpi_pkg::SW_RETRY_BASE[15:4], 2'b00, cur_retry};
          end
        end else if (cur_blocked) begin
          sw_d = cpi_pkg::SW_BLOCKED;
        end else if (cur_disabled) begin
          sw_d = cpi_pkg::SW_NOT_USABLE;
        end else if (pin_match) begin
          sw_d = cpi_pkg::SW_OK;
          v_good = 1'b1;
        end else begin
          sw_d = {cpi_pkg::SW_RETRY_BASE[15:4], 2'b00, cur_retry - 2'h1};
          v_bad = 1'b1;
        end
      end
      cpi_pkg::OP_INCREASE: begin
        if (!fcfg_q[cpi_pkg::FCFG_INC_BIT]) begin
          sw_d = cpi_pkg::SW_NOT_ALLOWED;
        end else if (!file_acc) begin
          sw_d = cpi_pkg::SW_SEC;
        end else if (inc_carry) begin
          sw_d = cpi_pkg::SW_MAX;
        end else begin
          sw_d = cpi_pkg::SW_OK;
        end
      end
      cpi_pkg::OP_ACCESS: sw_d = file_acc ? cpi_pkg::SW_OK : cpi_pkg::SW_SEC;
      default: sw_d = cpi_pkg::SW_BAD_OP;
    endcase
  end

  // Answer registers, one-cycle done pulse
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_q <= cpi_pkg::SW_RST;
      done_q <= 1'b0;
      resp_new_q <= cpi_pkg::REC_RST;
      resp_add_q <= cpi_pkg::REC_RST;
    end else begin
      done_q <= is_exec;
      if (is_exec) begin
        sw_q <= sw_d;
      end
      if (inc_ok) begin
        resp_new_q <= inc_sum_lo;
        resp_add_q <= inc_val_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // PIN state; all but the verified flags kept across session resets
  // ----------------------------------------------------------------
  // Retry counters, blocked, disabled and verified flags per PIN
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      retry_q <= '{default: cpi_pkg::RETRY_INIT};
      blocked_q <= '0;
      disabled_q <= '0;
      verified_q <= '0;
    end else begin
      for (int k = 0; k < cpi_pkg::NUM_PIN; k++) begin
        // Session reset drops only the security state
        if (ctrl_wr && i_wdata[cpi_pkg::CTRL_SESSION_BIT]) begin
          verified_q[k] <= 1'b0;
        end
        if (ctrl_wr && i_wdata[cpi_pkg::CTRL_KEY_BIT] == 1'(k)) begin
          if (i_wdata[cpi_pkg::CTRL_UNBLOCK_BIT]) begin
            blocked_q[k] <= 1'b0;
            retry_q[k] <= cpi_pkg::RETRY_INIT;
          end
          if (i_wdata[cpi_pkg::CTRL_DISABLE_BIT] && !blocked_q[k]) begin
            disabled_q[k] <= 1'b1;
          end
          if (i_wdata[cpi_pkg::CTRL_ENABLE_BIT]) begin
            disabled_q[k] <= 1'b0;
          end
        end
        // Command effects last, so a hardware set beats a control clear
        if (is_exec && cmd_key_q == 1'(k) && v_good) begin
          retry_q[k] <= cpi_pkg::RETRY_INIT;
          verified_q[k] <= 1'b1;
        end
        if (is_exec && cmd_key_q == 1'(k) && v_bad) begin
          retry_q[k] <= retry_q[k] - 2'h1;
          verified_q[k] <= 1'b0;
          if (retry_q[k] == 2'h1) begin
            blocked_q[k] <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Cyclic record store
  // ----------------------------------------------------------------
  // Sum into oldest record, pointer follows
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rec_q <= '{default: cpi_pkg::REC_RST};
      ptr_q <= '0;
    end else if (inc_ok) begin
      rec_q[oldest] <= inc_sum_lo;
      ptr_q <= oldest;
    end else if (i_wr && hit(i_addr, cpi_pkg::OFF_REC_LOAD) && !is_exec) begin
      rec_q[oldest] <= i_wdata[cpi_pkg::REC_W-1:0];
      ptr_q <= oldest;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Operand and configuration writes
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_data_q <= cpi_pkg::PIN_RST;
      inc_val_q <= cpi_pkg::REC_RST;
      fcfg_q <= '0;
      ref_pin_q <= '{default: cpi_pkg::PIN_RST};
    end else if (i_wr) begin
      if (hit(i_addr, cpi_pkg::OFF_PIN_DATA)) begin
        pin_data_q <= i_wdata;
      end
      if (hit(i_addr, cpi_pkg::OFF_INC_VAL)) begin
        inc_val_q <= i_wdata[cpi_pkg::REC_W-1:0];
      end
      if (hit(i_addr, cpi_pkg::OFF_FILE_CFG)) begin
        fcfg_q <= i_wdata[2:0];
      end
      if (hit(i_addr, cpi_pkg::OFF_REF_PIN0)) begin
        ref_pin_q[0] <= i_wdata;
      end
      if (hit(i_addr, cpi_pkg::OFF_REF_PIN1)) begin
        ref_pin_q[1] <= i_wdata;
      end
    end
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    rdata_d = '0;
    case (i_addr)
      cpi_pkg::OFF_CMD: rdata_d = {28'h0, cmd_key_q, cmd_empty_q, cmd_op_q};
      cpi_pkg::OFF_FILE_CFG: rdata_d = {29'h0, fcfg_q};
      cpi_pkg::OFF_INC_VAL: rdata_d = {8'h0, inc_val_q};
      cpi_pkg::OFF_STATUS: rdata_d = {15'h0, o_busy, sw_q};
      cpi_pkg::OFF_RESP_NEW: rdata_d = {8'h0, resp_new_q};
      cpi_pkg::OFF_RESP_ADD: rdata_d = {8'h0, resp_add_q};
      cpi_pkg::OFF_REC_CUR: rdata_d = {8'h0, rec_q[ptr_q]};
      cpi_pkg::OFF_PIN_STATE: begin
        for (int k = 0; k < cpi_pkg::NUM_PIN; k++) begin
          rdata_d[k*cpi_pkg::PSTATE_STRIDE +: 5] =
            {verified_q[k], disabled_q[k], blocked_q[k], retry_q[k]};
        end
      end
      default: rdata_d = '0;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_rd ? rdata_d : '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_verify_data;
    is_exec && cmd_op_q == cpi_pkg::OP_VERIFY && !cmd_empty_q;
  endsequence
  sequence s_verify_empty;
    is_exec && cmd_op_q == cpi_pkg::OP_VERIFY && cmd_empty_q;
  endsequence
  sequence s_inc_cmd;
    is_exec && cmd_op_q == cpi_pkg::OP_INCREASE;
  endsequence

  a_inc_sum_store: assert property (
    inc_ok |=> rec_q[ptr_q] == $past(inc_sum_lo))
    else $error("increase sum not stored in oldest record");
  a_inc_ptr_move: assert property (
    inc_ok |=> ptr_q == $past(oldest) && done_q && sw_q == cpi_pkg::SW_OK)
    else $error("record pointer did not follow write");
  a_inc_sec_refuse: assert property (
    s_inc_cmd and (fcfg_q[cpi_pkg::FCFG_INC_BIT] && !file_acc)
    |=> sw_q == cpi_pkg::SW_SEC && $stable(ptr_q))
    else $error("increase without access not refused");
  a_inc_resp_data: assert property (
    inc_ok |=> resp_new_q == $past(inc_sum_lo) && resp_add_q == $past(inc_val_q))
    else $error("increase response data wrong");
  a_inc_max_hold: assert property (
    s_inc_cmd and (inc_acc && inc_carry)
    |=> sw_q == cpi_pkg::SW_MAX && $stable(ptr_q) ##1 $stable(resp_new_q))
    else $error("overflowing increase not refused");
  a_inc_not_listed: assert property (
    s_inc_cmd and !fcfg_q[cpi_pkg::FCFG_INC_BIT] |=> sw_q == cpi_pkg::SW_NOT_ALLOWED)
    else $error("unlisted increase not refused");
  a_pin_match_ok: assert property (
    s_verify_data and (!cur_blocked && !cur_disabled && pin_match)
    |=> sw_q == cpi_pkg::SW_OK && verified_q[cmd_key_q] && retry_q[cmd_key_q] == 2'h3)
    else $error("matching PIN not accepted");
  a_verify_forms: assert property (
    is_exec && cmd_op_q == cpi_pkg::OP_VERIFY |=> done_q && sw_q != cpi_pkg::SW_BAD_OP)
    else $error("verify form not accepted");
  a_pin_disabled: assert property (
    s_verify_data and (!cur_blocked && cur_disabled)
    |=> sw_q == cpi_pkg::SW_NOT_USABLE && $stable(retry_q[cmd_key_q]))
    else $error("verify on disabled PIN not refused");
  a_access_gate: assert property (
    is_exec && cmd_op_q == cpi_pkg::OP_ACCESS && !file_acc |=> sw_q == cpi_pkg::SW_SEC)
    else $error("protected function not refused");
  a_retry_decrement: assert property (
    s_verify_data and v_bad
    |=> retry_q[cmd_key_q] == $past(cur_retry) - 2'h1 && sw_q[3:0] == {2'b00, retry_q[cmd_key_q]})
    else $error("wrong PIN did not decrement retries");
  a_third_blocks: assert property (
    s_verify_data and (v_bad && cur_retry == 2'h1)
    |=> blocked_q[cmd_key_q] && sw_q == 16'h63c0)
    else $error("third wrong PIN did not block");
  a_blocked_answer: assert property (
    s_verify_data and cur_blocked |=> sw_q == cpi_pkg::SW_BLOCKED && !verified_q[cmd_key_q])
    else $error("blocked PIN not answered 6983");
  a_blocked_no_acc: assert property (
    blocked_q[0] |-> !verified_q[0])
    else $error("blocked PIN still grants access");
  a_query_report: assert property (
    s_verify_empty and !cur_blocked
    |=> sw_q == {12'h63c, 2'b00, $past(cur_retry)} && $stable(retry_q[cmd_key_q]))
    else $error("retry query reported wrong count");
  a_query_blocked: assert property (
    s_verify_empty and cur_blocked |=> sw_q == 16'h63c0)
    else $error("retry query on blocked PIN wrong");
  a_session_keep: assert property (
    ctrl_wr && i_wdata[cpi_pkg::CTRL_SESSION_BIT] && !is_exec
    && i_wdata[cpi_pkg::CTRL_UNBLOCK_BIT] == 1'b0
    |=> $stable(retry_q[0]) && $stable(blocked_q) && $stable(ptr_q))
    else $error("session reset altered kept state");

endmodule

/* test/cpi_term.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Terminal model on the register port
// ----------------------------------------
module cpi_term (
  // Clock
  input wire logic i_core_clk,
  // Register port
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [31:0] i_rdata,
  // Command answer
  input wire logic [15:0] i_sw,
  input wire logic i_done,
  input wire logic i_busy
);
  // Idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One write cycle; bus scrambled once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // One read cycle; data taken in the cycle after
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask

  // Command write, busy in the next cycle, then bounded wait for done
  task automatic cmd(input logic [31:0] c, output logic [15:0] sw, output logic ok);
    logic bsy;
    ok = 1'b0;
    wr(cpi_pkg::OFF_CMD, c);
    #1 bsy = (i_busy === 1'b1);
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_core_clk);
      #1 ok = (i_done === 1'b1);
    end
    ok = ok && bsy && (i_busy === 1'b0);
    sw = i_sw;
  endtask

  // Verify with PIN value or with empty data
  task automatic vfy(input logic e, input logic k, input logic [31:0] p,
                     output logic [15:0] sw, output logic ok);
    if (!e) begin
      wr(cpi_pkg::OFF_PIN_DATA, p);
    end
    cmd({28'h0, k, e, cpi_pkg::OP_VERIFY}, sw, ok);
  endtask

  // Increase value is one whole 24-bit record
  task automatic inc(input logic [23:0] v, output logic [15:0] sw, output logic ok);
    wr(cpi_pkg::OFF_INC_VAL, {8'h00, v});
    cmd(32'h1, sw, ok);
  endtask
endmodule

/* test/cpi_top_test.sv */
`timescale 1ns/10ps
module cpi_top_test;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [15:0] o_sw;
  logic o_done;
  logic o_busy;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [31:0] PIN = 32'h12345678;

  cpi_top cpi_top_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sw(o_sw),
    .o_done(o_done), .o_busy(o_busy));
  cpi_term cpi_term_i (.i_core_clk(i_core_clk), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata), .i_sw(o_sw), .i_done(o_done),
    .i_busy(o_busy));

  // 10 MHz clock
  always #50 i_core_clk = ~i_core_clk;

  // Verdict and end of run
  task automatic close_out();
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Register read and compare
  task automatic rg(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] d;
    cpi_term_i.rd(a, d);
    chk("register", x, d);
  endtask

  // Done flag and status word of a command
  task automatic sw_chk(input logic ok, input logic [15:0] sw, input logic [15:0] x);
    chk("done and status", {15'h0, 1'b1, x}, {15'h0, ok, sw});
  endtask

  task automatic vf(input logic e, input logic k, input logic [31:0] p, input logic [15:0] x);
    logic [15:0] sw;
    logic ok;
    cpi_term_i.vfy(e, k, p, sw, ok);
    sw_chk(ok, sw, x);
  endtask

  task automatic ic(input logic [23:0] v, input logic [15:0] x);
    logic [15:0] sw;
    logic ok;
    cpi_term_i.inc(v, sw, ok);
    sw_chk(ok, sw, x);
  endtask

  task automatic op(input logic [31:0] c, input logic [15:0] x);
    logic [15:0] sw;
    logic ok;
    cpi_term_i.cmd(c, sw, ok);
    sw_chk(ok, sw, x);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rg(cpi_pkg::OFF_PIN_STATE, 32'h00000303);
    chk("sw after reset", 32'h0, {16'h0, o_sw});
    cpi_term_i.wr(cpi_pkg::OFF_REF_PIN0, PIN);
    cpi_term_i.wr(cpi_pkg::OFF_FILE_CFG, 32'h3);
    cpi_term_i.wr(cpi_pkg::OFF_REC_LOAD, 32'h000001);
    ic(24'h000002, 16'h6982);
    op(32'h3, 16'h6d00);
    $display("Test access done");
    vf(1'b0, 1'b0, ~PIN, 16'h63c2);
    vf(1'b0, 1'b0, ~PIN, 16'h63c1);
    cpi_term_i.wr(cpi_pkg::OFF_CTRL, 32'h1);
    vf(1'b1, 1'b0, PIN, 16'h63c1);
    vf(1'b1, 1'b1, PIN, 16'h63c3);
    vf(1'b0, 1'b0, PIN, 16'h9000);
    vf(1'b1, 1'b0, PIN, 16'h63c3);
    $display("Test verify done");
    ic(24'h000003, 16'h9000);
    rg(cpi_pkg::OFF_RESP_NEW, 32'h000004);
    rg(cpi_pkg::OFF_RESP_ADD, 32'h000003);
    ic(24'h010200, 16'h9000);
    rg(cpi_pkg::OFF_REC_CUR, 32'h010204);
    ic(24'hff0000, 16'h9850);
    rg(cpi_pkg::OFF_REC_CUR, 32'h010204);
    ic(24'h00fffd, 16'h9000);
    rg(cpi_pkg::OFF_RESP_NEW, 32'h020201);
    rg(cpi_pkg::OFF_RESP_ADD, 32'h00fffd);
    cpi_term_i.wr(cpi_pkg::OFF_FILE_CFG, 32'h2);
    ic(24'h000001, 16'h6986);
    cpi_term_i.wr(cpi_pkg::OFF_FILE_CFG, 32'h3);
    $display("Test increase done");
    vf(1'b0, 1'b0, ~PIN, 16'h63c2);
    vf(1'b0, 1'b0, ~PIN, 16'h63c1);
    cpi_term_i.wr(cpi_pkg::OFF_CTRL, 32'h1);
    vf(1'b0, 1'b0, ~PIN, 16'h63c0);
    rg(cpi_pkg::OFF_PIN_STATE, 32'h00000304);
    vf(1'b0, 1'b0, ~PIN, 16'h6983);
    vf(1'b0, 1'b0, PIN, 16'h6983);
    vf(1'b1, 1'b0, PIN, 16'h63c0);
    op(32'h2, 16'h6982);
    ic(24'h000001, 16'h6982);
    $display("Test blocking done");
    cpi_term_i.wr(cpi_pkg::OFF_CTRL, 32'h2);
    vf(1'b1, 1'b0, PIN, 16'h63c3);
    op(32'h2, 16'h6982);
    cpi_term_i.wr(cpi_pkg::OFF_CTRL, 32'h4);
    op(32'h2, 16'h9000);
    vf(1'b0, 1'b0, PIN, 16'h6984);
    vf(1'b1, 1'b0, PIN, 16'h63c3);
    cpi_term_i.wr(cpi_pkg::OFF_CTRL, 32'h8);
    vf(1'b0, 1'b0, PIN, 16'h9000);
    rg(cpi_pkg::OFF_STATUS, 32'h00009000);
    vf(1'b1, 1'b1, PIN, 16'h63c3);
    rg(cpi_pkg::OFF_CMD, 32'h0000000c);
    $display("Test disable done");
    close_out();
  end
endmodule
